// ===== src/dmacc_pkg.sv
// Constants, register map and carrier types of the DMA channel control block.
// Assumes a 32-bit classic Wishbone register bus and a 16-bit data space behind the engine.
package dmacc_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int          NCH        = 4;
    localparam int          NSRC       = 128;
    localparam logic [15:0] SFR_TOP    = 16'h07FF;
    localparam logic [15:0] RAM_TOP    = 16'h4FFF;
    localparam logic [15:0] RST_REG    = 16'h0000;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  ADR_ENGINE = 8'h00;
    localparam logic [7:0]  ADR_HIGH   = 8'h04;
    localparam logic [7:0]  ADR_LOW    = 8'h08;
    localparam logic [7:0]  ADR_BUF    = 8'h0C;
    localparam logic [4:0]  CH_CTL     = 5'h00;
    localparam logic [4:0]  CH_INT     = 5'h04;
    localparam logic [4:0]  CH_SRC     = 5'h08;
    localparam logic [4:0]  CH_DST     = 5'h0C;
    localparam logic [4:0]  CH_CNT     = 5'h10;

    // ------------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------------
    localparam int          ENG_EN     = 15;
    localparam int          ENG_PRS    = 0;
    localparam logic [15:0] ENG_WMASK  = 16'h8001;
    localparam int          CTL_NULL_WRITE_ENABLE  = 10;
    localparam int          CTL_RELOAD = 9;
    localparam int          CTL_REQ    = 8;
    localparam int          CTL_SA     = 6;
    localparam int          CTL_DA     = 4;
    localparam int          CTL_TR     = 2;
    localparam int          CTL_SIZE   = 1;
    localparam int          CTL_EN     = 0;
    localparam logic [15:0] CTL_WMASK  = 16'h07FF;
    localparam int          INT_BUFW   = 15;
    localparam int          INT_SEL    = 8;
    localparam int          INT_HIGH   = 7;
    localparam int          INT_LOW    = 6;
    localparam int          INT_DONE   = 5;
    localparam int          INT_HALF   = 4;
    localparam int          INT_OVR    = 3;
    localparam int          INT_HALFWAY_INTERRUPT_ENABLE = 0;
    localparam logic [15:0] INT_WMASK  = 16'h7FF9;

    // Address mode encodings (increment and decrement).
    localparam logic [1:0]  AM_INC     = 2'b01;
    localparam logic [1:0]  AM_DEC     = 2'b10;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_READ  = 5'b00010,
        ST_WRITE = 5'b00100,
        ST_NULL  = 5'b01000,
        ST_FIN   = 5'b10000
    } dmacc_state_e;

    typedef struct packed {
        logic        req;
        logic        we;
        logic        byte_sel;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dmacc_mem_req_s;

endpackage : dmacc_pkg

// ===== src/dmacc_top.sv
// Four-channel DMA engine: register file on classic Wishbone, arbiter and transfer sequencer.
// Assumes triggers and the data-space port run on clk_i; mem_ack_i may be held off any time.
//
// Contract
// R01 - Engine enable bit 15 runs the engine; clearing it aborts every channel operation.
// R02 - Engine bit 0 picks round-robin when set, fixed priority when clear.
// R03 - Null-write mode adds a dummy source write for each destination write.
// R04 - Reload bit restores source, destination and count at the next operation start.
// R05 - Repeated transfer modes always reload the count regardless of reload bit.
// R06 - Only the original count is stored; pointers are recovered from it.
// R07 - Software request starts a channel, hardware clears it when the transfer ends.
// R08 - Source mode: 11 indirect fixed, 10 decrement, 01 increment, 00 fixed.
// R09 - Destination mode uses the same encoding for the destination pointer.
// R10 - Transfer mode: 11 repeated continuous, 10 continuous, 01 repeated one-shot, 00 one-shot.
// R11 - Size bit 1 moves bytes when set, words when clear (reset value).
// R12 - Channel enable bit 0 activates the channel.
// R13 - Buffered-write flag reads 1 until the buffer has been written out.
// R14 - Seven-bit trigger select in bits 14-8 chooses the triggering source.
// R15 - High-limit flag sets on access above high limit or top of RAM.
// R16 - Low-limit flag sets on access below low limit but above 07FFh.
// R17 - Limit violations are detected only when the access is performed.
// R18 - Completion flag set on completed session, cleared while a session runs.
// R19 - Halfway flag sets when the count reaches half of its original value.
// R20 - Overrun flag sets on a trigger while the previous operation still runs.
// R21 - Halfway enable adds a halfway interrupt to the completion interrupt.
// R22 - Software writing flags to one never raises an interrupt.
// R23 - An out-of-limit access aborts the transaction and raises an interrupt.
// R24 - For bytes the address LSB selects upper or lower byte of the word.
// R25 - Fixed priority: lowest wins, but the just-served channel yields once.
// R26 - Unimplemented bits ignore writes and read as zero.
module dmacc_top
    import dmacc_pkg::*;
#(
    parameter logic [15:0] RAM_LIMIT = RAM_TOP
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic [NSRC-1:0]   trig_i,
    output dmacc_mem_req_s         mem_o,
    input  wire logic [15:0]       mem_rdata_i,
    input  wire logic              mem_ack_i,
    output logic      [NCH-1:0]    irq_o
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [15:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    // Fixed and indirect modes keep the pointer.
    function automatic logic [15:0] advance(input logic [15:0] ptr, input logic [1:0] mode,
                                            input logic [15:0] step);
        if (mode == AM_INC) begin
            advance = ptr + step;
        end else if (mode == AM_DEC) begin
            advance = ptr - step;
        end else begin
            advance = ptr;
        end
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0]      eng_q;
    logic [15:0]      hi_q;
    logic [15:0]      lo_q;
    logic [15:0]      buf_q;
    logic [15:0]      ctl_q    [NCH];
    logic [15:0]      int_q    [NCH];
    logic [15:0]      src_q    [NCH];
    logic [15:0]      dst_q    [NCH];
    logic [15:0]      cnt_q    [NCH];
    logic [15:0]      orig_q   [NCH];
    logic [NCH-1:0]   pend_q;
    logic [NCH-1:0]   busy_q;
    logic [NCH-1:0]   rld_q;
    logic [1:0]       cur_q;
    logic [1:0]       last_q;
    logic             bufw_q;
    logic [NCH-1:0]   irq_q;
    logic             ack_q;
    logic [31:0]      dat_q;
    dmacc_state_e     state_q;

    // ------------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------------
    wire              bus_acc  = wb_cyc_i & wb_stb_i;
    wire              bus_wr   = bus_acc & wb_we_i & ack_q;
    wire [15:0]       wmask    = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [15:0]       wdat     = wb_dat_i[15:0];
    wire [2:0]        ch_blk   = wb_adr_i[7:5];
    wire              ch_hit   = (ch_blk != 3'd0) && (ch_blk <= 3'(NCH));
    wire [1:0]        ch_sel   = 2'(ch_blk - 3'd1);
    wire [4:0]        ch_reg   = wb_adr_i[4:0];
    wire              eng_on   = eng_q[ENG_EN];

    logic [15:0]      rd_val;
    always_comb begin
        rd_val = 16'h0000;
        if (wb_adr_i == ADR_ENGINE) rd_val = eng_q;
        if (wb_adr_i == ADR_HIGH)   rd_val = hi_q;
        if (wb_adr_i == ADR_LOW)    rd_val = lo_q;
        if (wb_adr_i == ADR_BUF)    rd_val = buf_q;
        if (ch_hit && ch_reg == CH_CTL) rd_val = ctl_q[ch_sel];
        if (ch_hit && ch_reg == CH_INT) rd_val = {bufw_q, int_q[ch_sel][14:0]}; // R13
        if (ch_hit && ch_reg == CH_SRC) rd_val = src_q[ch_sel];
        if (ch_hit && ch_reg == CH_DST) rd_val = dst_q[ch_sel];
        if (ch_hit && ch_reg == CH_CNT) rd_val = cnt_q[ch_sel];
    end

    // Ack one cycle after the strobe; data zero-extended.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_acc & ~ack_q;
            dat_q <= {16'h0000, rd_val};
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // ------------------------------------------------------------------
    // Triggers and arbitration
    // ------------------------------------------------------------------
    logic [NCH-1:0] hw_trig;
    logic [NCH-1:0] sw_trig;
    for (genvar n = 0; n < NCH; n++) begin : g_trig
        wire act = eng_on & ctl_q[n][CTL_EN];                                   // R12
        assign hw_trig[n] = act & trig_i[int_q[n][INT_SEL +: 7]];               // R14
        assign sw_trig[n] = act & ctl_q[n][CTL_REQ] & ~pend_q[n] & ~busy_q[n];  // R07
    end

    // The channel served last is masked only when someone else is waiting.
    wire [NCH-1:0] cand_fix = ((pend_q & ~(4'b0001 << last_q)) != '0) ?
                              (pend_q & ~(4'b0001 << last_q)) : pend_q;         // R25
    logic [1:0] grant;
    logic       grant_v;
    always_comb begin
        logic [1:0] idx;
        grant   = 2'd0;
        grant_v = 1'b0;
        idx     = 2'd0;
        for (int k = 0; k < NCH; k++) begin
            if (eng_q[ENG_PRS]) begin
                idx = 2'(last_q + 2'd1 + 2'(k));                                // R02
            end else begin
                idx = 2'(k);
            end
            if (!grant_v && (eng_q[ENG_PRS] ? pend_q[idx] : cand_fix[idx])) begin
                grant   = idx;
                grant_v = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Current transfer datapath
    // ------------------------------------------------------------------
    wire [15:0] c_ctl   = ctl_q[cur_q];
    wire        c_byte  = c_ctl[CTL_SIZE];                                      // R11
    wire [15:0] c_step  = c_byte ? 16'h0001 : 16'h0002;
    wire [15:0] c_addr  = (state_q == ST_WRITE) ? dst_q[cur_q] : src_q[cur_q];
    wire        in_acc  = (state_q == ST_READ) | (state_q == ST_WRITE) | (state_q == ST_NULL);
    wire        v_high  = in_acc & (c_addr > SFR_TOP) &
                          ((c_addr > hi_q) | (c_addr > RAM_LIMIT));             // R15 R17
    wire        v_low   = in_acc & (c_addr > SFR_TOP) & (c_addr < lo_q);        // R16 R17
    wire        c_abort = v_high | v_low;
    wire [7:0]  rd_byte = src_q[cur_q][0] ? mem_rdata_i[15:8] : mem_rdata_i[7:0]; // R24
    wire [15:0] cnt_dec = cnt_q[cur_q] - 16'h0001;
    wire        c_last  = (cnt_dec == 16'h0000);
    wire        c_half  = (cnt_dec == (orig_q[cur_q] >> 1)) & (orig_q[cur_q] > 16'h0001);
    wire [15:0] c_span  = c_byte ? orig_q[cur_q] : 16'(orig_q[cur_q] << 1);
    wire        c_rep   = c_ctl[CTL_TR]; // Low mode bit marks repeated modes.
    wire        c_cont  = c_ctl[CTL_TR + 1];

    // Accesses stall while the data space holds off its acknowledge.
    assign mem_o.req      = in_acc & ~c_abort & eng_on;
    assign mem_o.we       = (state_q != ST_READ);
    assign mem_o.byte_sel = c_byte;
    assign mem_o.addr     = c_addr;
    assign mem_o.wdata    = c_byte ? {buf_q[7:0], buf_q[7:0]} : buf_q;         // R24
    assign irq_o          = irq_q;

    // ------------------------------------------------------------------
    // Registers, channel state and sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eng_q   <= RST_REG;
            hi_q    <= RST_REG;
            lo_q    <= RST_REG;
            buf_q   <= RST_REG;
            pend_q  <= '0;
            busy_q  <= '0;
            rld_q   <= '0;
            cur_q   <= 2'd0;
            last_q  <= 2'd0;
            bufw_q  <= 1'b0;
            irq_q   <= '0;
            state_q <= ST_IDLE;
            for (int n = 0; n < NCH; n++) begin
                ctl_q[n]  <= RST_REG;
                int_q[n]  <= RST_REG;
                src_q[n]  <= RST_REG;
                dst_q[n]  <= RST_REG;
                cnt_q[n]  <= RST_REG;
                orig_q[n] <= RST_REG;
            end
        end else begin
            irq_q <= '0;
            // Software writes; flags written here never pulse irq_q.       R22
            if (bus_wr) begin
                if (wb_adr_i == ADR_ENGINE) eng_q <= merge(eng_q, wdat, wmask & ENG_WMASK); // R26
                if (wb_adr_i == ADR_HIGH)   hi_q  <= merge(hi_q, wdat, wmask);
                if (wb_adr_i == ADR_LOW)    lo_q  <= merge(lo_q, wdat, wmask);
                if (wb_adr_i == ADR_BUF)    buf_q <= merge(buf_q, wdat, wmask);
                if (ch_hit) begin
                    if (ch_reg == CH_CTL)
                        ctl_q[ch_sel] <= merge(ctl_q[ch_sel], wdat, wmask & CTL_WMASK); // R26
                    if (ch_reg == CH_INT)
                        int_q[ch_sel] <= merge(int_q[ch_sel], wdat, wmask & INT_WMASK); // R26
                    if (ch_reg == CH_SRC) src_q[ch_sel] <= merge(src_q[ch_sel], wdat, wmask);
                    if (ch_reg == CH_DST) dst_q[ch_sel] <= merge(dst_q[ch_sel], wdat, wmask);
                    if (ch_reg == CH_CNT) begin
                        cnt_q[ch_sel]  <= merge(cnt_q[ch_sel], wdat, wmask);
                        orig_q[ch_sel] <= merge(cnt_q[ch_sel], wdat, wmask);  // R06
                        rld_q[ch_sel]  <= 1'b0;
                    end
                end
            end
            // Hardware flag sets come after bus writes so they win.
            for (int n = 0; n < NCH; n++) begin
                if (hw_trig[n] & (pend_q[n] | busy_q[n])) int_q[n][INT_OVR] <= 1'b1; // R20
                else if (hw_trig[n] | sw_trig[n]) pend_q[n] <= 1'b1;
            end
            unique case (state_q)
                ST_IDLE: begin
                    if (grant_v & eng_on) begin
                        cur_q         <= grant;
                        last_q        <= grant;
                        pend_q[grant] <= 1'b0;
                        busy_q[grant] <= 1'b1;
                        int_q[grant][INT_DONE] <= 1'b0;                          // R18
                        state_q       <= ST_READ;
                        if (rld_q[grant]) begin
                            rld_q[grant] <= 1'b0;
                            if (ctl_q[grant][CTL_RELOAD] | ctl_q[grant][CTL_TR])
                                cnt_q[grant] <= orig_q[grant];                   // R04 R05
                            if (ctl_q[grant][CTL_RELOAD]) begin
                                src_q[grant] <= advance(src_q[grant],
                                    ~ctl_q[grant][CTL_SA +: 2],
                                    ctl_q[grant][CTL_SIZE] ? orig_q[grant] :
                                    16'(orig_q[grant] << 1));                    // R04 R06
                                dst_q[grant] <= advance(dst_q[grant],
                                    ~ctl_q[grant][CTL_DA +: 2],
                                    ctl_q[grant][CTL_SIZE] ? orig_q[grant] :
                                    16'(orig_q[grant] << 1));                    // R04 R06
                            end
                        end
                    end
                end
                ST_READ: begin
                    if (mem_ack_i & ~c_abort) begin
                        buf_q   <= c_byte ? {8'h00, rd_byte} : mem_rdata_i;     // R11 R24
                        bufw_q  <= 1'b1;                                         // R13
                        state_q <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (mem_ack_i & ~c_abort) begin
                        bufw_q  <= c_ctl[CTL_NULL_WRITE_ENABLE];                             // R13
                        state_q <= c_ctl[CTL_NULL_WRITE_ENABLE] ? ST_NULL : ST_FIN;          // R03
                    end
                end
                ST_NULL: begin
                    if (mem_ack_i & ~c_abort) begin
                        bufw_q  <= 1'b0;                                         // R13
                        state_q <= ST_FIN;
                    end
                end
                ST_FIN: begin
                    src_q[cur_q] <= advance(src_q[cur_q], c_ctl[CTL_SA +: 2], c_step); // R08
                    dst_q[cur_q] <= advance(dst_q[cur_q], c_ctl[CTL_DA +: 2], c_step); // R09
                    cnt_q[cur_q] <= cnt_dec;
                    if (c_half) begin
                        int_q[cur_q][INT_HALF] <= 1'b1;                          // R19
                        if (int_q[cur_q][INT_HALFWAY_INTERRUPT_ENABLE]) irq_q[cur_q] <= 1'b1;      // R21
                    end
                    if (c_last) begin
                        int_q[cur_q][INT_DONE] <= 1'b1;                          // R18
                        irq_q[cur_q]           <= 1'b1;                          // R21
                        rld_q[cur_q]           <= 1'b1;
                        if (!c_rep) ctl_q[cur_q][CTL_EN] <= 1'b0;                // R10
                    end
                    if (c_cont & ~c_last) begin
                        state_q <= ST_READ;                                      // R10
                    end else begin
                        busy_q[cur_q]           <= 1'b0;
                        ctl_q[cur_q][CTL_REQ]   <= 1'b0;                         // R07
                        state_q                 <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            // Limit violation ends the transaction at the faulting access.
            if (c_abort) begin
                if (v_high) int_q[cur_q][INT_HIGH] <= 1'b1;                      // R15
                if (v_low)  int_q[cur_q][INT_LOW]  <= 1'b1;                      // R16
                irq_q[cur_q]         <= 1'b1;                                    // R23
                busy_q[cur_q]        <= 1'b0;
                ctl_q[cur_q][CTL_REQ] <= 1'b0;
                bufw_q               <= 1'b0;
                state_q              <= ST_IDLE;                                 // R23
            end
            // Engine disable drops every pending and running operation.
            if (!eng_on) begin
                pend_q  <= '0;                                                   // R01
                busy_q  <= '0;                                                   // R01
                state_q <= ST_IDLE;                                              // R01
            end
        end
    end

endmodule : dmacc_top

// ===== testbench/dmacc_chk.sv
// Port checker for the DMA channel control top.
// Assumes one clock and the synchronous active-high reset.
module dmacc_chk
    import dmacc_pkg::*;
#(
    parameter logic [15:0] RAM_LIMIT = RAM_TOP
) (
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic           wb_cyc_i,
    input  wire logic           wb_stb_i,
    input  wire logic           wb_we_i,
    input  wire logic [7:0]     wb_adr_i,
    input  wire logic [3:0]     wb_sel_i,
    input  wire logic [31:0]    wb_dat_i,
    input  wire logic [31:0]    wb_dat_o,
    input  wire logic           wb_ack_o,
    input  wire dmacc_mem_req_s mem_o,
    input  wire logic           mem_ack_i,
    input  wire logic [NCH-1:0] irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire go     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_off = wb_ack_o && wb_we_i && wb_adr_i == ADR_ENGINE && wb_sel_i[1] && !wb_dat_i[15];
    chk_ack_next: assert property (go |=> wb_ack_o ##1 !wb_ack_o)
        else $error("register access not acknowledged once");
    chk_unmapped_zero: assert property (go && !wb_we_i && wb_adr_i == 8'h10 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    chk_byte_lanes: assert property (mem_o.req && mem_o.we && mem_o.byte_sel
        |-> mem_o.wdata[15:8] == mem_o.wdata[7:0]) else $error("byte not on both lanes");
    chk_ram_top: assert property (mem_o.req |-> mem_o.addr <= RAM_LIMIT)
        else $error("access above data space top");
    chk_req_hold: assert property (mem_o.req && !mem_ack_i |=> !mem_o.req || $stable(mem_o.addr))
        else $error("access address moved before answer");
    chk_abort_off: assert property (wr_off |-> ##2 !mem_o.req [*3])
        else $error("engine still requesting after disable");
    chk_irq_pulse: assert property (irq_o[0] |=> !irq_o[0])
        else $error("interrupt longer than one cycle");
    cover property (mem_o.req && mem_o.byte_sel && mem_ack_i);
    cover property (irq_o[0]);
    cover property (wr_off);
endmodule // dmacc_chk

// ===== testbench/dmacc_mem_model.sv
// Data-space partner: word memory acking after a random wait.
// Assumes requests hold steady until acknowledged.
module dmacc_mem_model
    import dmacc_pkg::*;
(
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire dmacc_mem_req_s mem_i,
    output logic [15:0]         rdata_o,
    output logic                ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:32767];
    logic [15:0] rnd_q  = 16'h1ACE;
    int          wr_cnt = 0;
    always @(posedge clk_i) begin
        rnd_q   <= {rnd_q[14:0], rnd_q[15] ^ rnd_q[13] ^ rnd_q[12] ^ rnd_q[10]};
        ack_o   <= 1'b0;
        // Idle data flips so stale read data is never mistaken for an answer.
        rdata_o <= ~rdata_o;
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (mem_i.req && !ack_o && rnd_q[1:0] != 2'b00) begin
            ack_o <= 1'b1;
            if (!mem_i.we) begin
                rdata_o <= mem[mem_i.addr[15:1]];
            end else begin
                wr_cnt <= wr_cnt + 1;
                if (!mem_i.byte_sel || !mem_i.addr[0]) mem[mem_i.addr[15:1]][7:0] <= mem_i.wdata[7:0];
                if (!mem_i.byte_sel || mem_i.addr[0]) mem[mem_i.addr[15:1]][15:8] <= mem_i.wdata[15:8];
            end
        end
    end
endmodule // dmacc_mem_model

// ===== testbench/dmacc_test.sv
// Self-checking bench for the DMA channel control block.
// Assumes checker and memory model compiled first.
module dmacc_test
    import dmacc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]      wb_adr_i = 8'h00;
    logic [3:0]      wb_sel_i = 4'h3;
    logic [31:0]     wb_dat_i = 32'h0, wb_dat_o;
    logic            wb_ack_o, mem_ack_i;
    logic [NSRC-1:0] trig_i = '0;
    logic [NCH-1:0]  irq_o;
    logic [15:0]     mem_rdata_i, rd, sa, da, rnd = 16'h5C1D;
    dmacc_mem_req_s  mem_o;
    int error_cnt = 0, compares = 0, cyc_cnt = 0, irq_cnt = 0, w0 = 0, n = 0;
    dmacc_top dmacc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trig_i(trig_i), .mem_o(mem_o),
        .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i), .irq_o(irq_o));
    dmacc_mem_model dmacc_mem_model_i (.clk_i(clk_i), .rst_i(rst_i), .mem_i(mem_o),
        .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [15:0] rdm(input logic [15:0] a, input bit b);
        logic [15:0] w;
        w = dmacc_mem_model_i.mem[a[15:1]];
        if (!b) return w;
        return a[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic bus(input logic we, input logic [7:0] adr, input logic [15:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {16'h0000, dat};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] adr, input logic [15:0] exp);
        bus(1'b0, adr, 16'h0000);
        check(rd, exp);
    endtask
    task automatic poll(input int b);
        n = 0;
        do begin
            bus(1'b0, 8'h24, 16'h0000);
            n++;
        end while (rd[b] !== 1'b1 && n < 100);
    endtask
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (irq_o[0] === 1'b1) irq_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    initial begin
        for (int j = 16'h0800; j < 16'h0900; j++) begin
            rnd = lfsr(rnd);
            dmacc_mem_model_i.mem[j] = rnd;
        end
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b1, ADR_ENGINE, 16'hFFFF);
        rchk(ADR_ENGINE, 16'h8001);
        bus(1'b1, 8'h20, 16'hFEFE);
        rchk(8'h20, 16'h06FE);
        bus(1'b1, 8'h24, 16'hFFFF);
        rchk(8'h24, 16'h7FF9);
        check(16'(irq_cnt), 16'h0000);
        rchk(8'h10, 16'h0000);
        bus(1'b1, ADR_HIGH, 16'h4FFF);
        // Word run up, byte run with source down and destination up, with dummy writes.
        for (int k = 0; k < 2; k++) begin
            irq_cnt = 0;
            w0 = dmacc_mem_model_i.wr_cnt;
            bus(1'b1, 8'h24, 16'h0001);
            bus(1'b1, 8'h28, k ? 16'h1107 : 16'h1000);
            bus(1'b1, 8'h2C, k ? 16'h3000 : 16'h2000);
            bus(1'b1, 8'h30, 16'h0004);
            bus(1'b1, 8'h20, k ? 16'h059B : 16'h0159);
            poll(5);
            rchk(8'h24, 16'h0031);
            rchk(8'h20, k ? 16'h049A : 16'h0058);
            check(16'(irq_cnt), 16'h0002);
            check(16'(dmacc_mem_model_i.wr_cnt - w0), k ? 16'h0008 : 16'h0004);
            for (int i = 0; i < 4; i++) begin
                sa = k ? 16'(16'h1107 - i) : 16'(16'h1000 + 2 * i);
                da = k ? 16'(16'h3000 + i) : 16'(16'h2000 + 2 * i);
                check(rdm(da, k), rdm(sa, k));
            end
        end
        irq_cnt = 0;
        w0 = dmacc_mem_model_i.wr_cnt;
        bus(1'b1, ADR_HIGH, 16'h1FFF);
        bus(1'b1, 8'h24, 16'h0500);
        bus(1'b1, 8'h30, 16'h0001);
        bus(1'b1, 8'h20, 16'h0001);
        // Second cycle of the two-cycle trigger pulse overruns the pending channel.
        @(posedge clk_i);
        trig_i[5] <= 1'b1;
        repeat (2) @(posedge clk_i);
        trig_i[5] <= 1'b0;
        poll(7);
        rchk(8'h24, 16'h0588);
        check(16'(irq_cnt != 0), 16'h0001);
        check(16'(dmacc_mem_model_i.wr_cnt - w0), 16'h0000);
        bus(1'b1, ADR_ENGINE, 16'h0000);
        rchk(8'h20, 16'h0001);
        stop_test();
    end
endmodule // dmacc_test
bind dmacc_top dmacc_chk #(.RAM_LIMIT(RAM_LIMIT)) dmacc_chk_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mem_o(mem_o), .mem_ack_i(mem_ack_i), .irq_o(irq_o));
